// [rtl/cepg_pkg.sv]
//==============================================================
// Contract
// RULE1 - Position mode: count encoder edges, capture count on each configurable sample edge.
// RULE2 - Sample edges never clear position count; captures are cumulative and streamed out.
// RULE3 - Edge-separation: counting of count-input edges begins on active start edge.
// RULE4 - Further start edges are ignored while a separation count runs.
// RULE5 - Active window edge stops the separation count and pushes it to results.
// RULE6 - Start and window edge polarities are selectable independently.
// RULE7 - Single separation: after one stored count, all further edges are ignored.
// RULE8 - Implicit buffered separation stores each interval and re-arms for the next.
// RULE9 - Sample-clocked separation pushes the completed count on a sample edge.
// RULE10 - Sample-clocked separation flags overrun unless start and window edges both occurred.
// RULE11 - Single pulse: delay and width counted in selectable-polarity count-input edges.
// RULE12 - With start trigger, one pulse per trigger, delay measured from trigger.
// RULE13 - Embedded pulse counter halts finite trains at the programmed pulse count.
// RULE14 - Retriggerable: window ignored during generation, then wait for next trigger.
// RULE15 - Delay on every retrigger is selectable; defaults single all, finite first.
// RULE16 - No pause trigger while the window input serves as start trigger.
// RULE17 - Sources allow two count-input ticks between trigger and first edge; the code waits delay_ticks ticks, at least one.
// RULE18 - Continuous train: programmable high/low widths, start on arm or trigger.
// RULE19 - Window as pause trigger suspends generation while asserted.
// RULE20 - Continuous output frequency is count-input frequency divided by M plus N.
// RULE21 - Buffered trains: implicit sample per pulse, or update on sample edge.
// RULE22 - Implicit ignores initial widths; sample-clocked uses them until first sample.
// RULE23 - Arm clears the count and all pending measurement state.
//==============================================================
package cepg_pkg;
  localparam int unsigned CEPG_CW        = 32;
  localparam int unsigned CEPG_BUF_DEPTH = 2;
  localparam logic [1:0]  CEPG_KIND_POS  = 2'h1;
  localparam logic [1:0]  CEPG_KIND_SEP  = 2'h2;

  // Operating modes, one-hot
  typedef enum logic [8:0] {
    CEPG_POS      = 9'h001,
    CEPG_SEP_ONE  = 9'h002,
    CEPG_SEP_IMPL = 9'h004,
    CEPG_SEP_SCLK = 9'h008,
    CEPG_PULSE    = 9'h010,
    CEPG_FINITE   = 9'h020,
    CEPG_CONT     = 9'h040,
    CEPG_BUF_IMPL = 9'h080,
    CEPG_BUF_SCLK = 9'h100
  } cepg_mode_type;

  // Static configuration flags
  typedef struct packed {
    cepg_mode_type mode;
    logic          count_rise;
    logic          start_rise;
    logic          window_rise;
    logic          sample_rise;
    logic          trig_en;
    logic          retrig;
    logic          pause_en;
    logic          delay_policy_set;
    logic          delay_every_retrigger;
  } cepg_cfg_type;

  typedef struct packed {
    logic [1:0]         kind;
    logic [CEPG_CW-1:0] value;
  } cepg_result_type;

  typedef struct packed {
    logic [CEPG_CW-1:0] idle;
    logic [CEPG_CW-1:0] active;
  } cepg_spec_type;
endpackage

// [rtl/cepg_top.sv]
`timescale 1ns/100ps
module cepg_top import cepg_pkg::*; #(
  parameter int unsigned CW = CEPG_CW
) (
  input  wire logic            mclk,
  input  wire logic            reset,
  input  wire logic            arm,
  input  wire cepg_cfg_type    cfg,
  input  wire logic [CW-1:0]   delay_ticks,
  input  wire logic [CW-1:0]   high_ticks,
  input  wire logic [CW-1:0]   low_ticks,
  input  wire logic [CW-1:0]   pulse_total,
  input  wire logic            count_in,
  input  wire logic            start_in,
  input  wire logic            window_in,
  input  wire logic            sample_in,
  input  wire cepg_spec_type   spec,
  input  wire logic            spec_valid,
  output logic                 spec_ready,
  output cepg_result_type      res_data,
  output logic                 res_valid,
  input  wire logic            res_ready,
  output logic                 overrun,
  output logic                 res_lost,
  output logic                 meas_done,
  output logic                 gen_done,
  output logic                 pulse_out
);
  // Widths must fit the result word; below two bits a phase count is meaningless
  if (CW < 2 || CW > CEPG_CW) begin : g_cw_check
    $error("cepg_top: CW out of range");
  end

  typedef enum logic [3:0] {
    M_IDLE = 4'h1, M_WAIT = 4'h2, M_COUNT = 4'h4, M_DONE = 4'h8
  } cepg_mstate_type;
  typedef enum logic [6:0] {
    G_IDLE = 7'h01, G_TRIG = 7'h02, G_DELAY = 7'h04, G_FETCH = 7'h08,
    G_LOW  = 7'h10, G_HIGH = 7'h20, G_DONE  = 7'h40
  } cepg_gstate_type;

  //==============================================================
  // Edge detection
  //==============================================================
  logic [3:0] prev;
  wire  [3:0] ins   = {sample_in, window_in, start_in, count_in};
  wire  [3:0] pols  = {cfg.sample_rise, cfg.window_rise, cfg.start_rise, cfg.count_rise};
  // Active edge when the level changed and now equals the polarity bit
  wire  [3:0] edges = (ins ^ prev) & ~(ins ^ pols); // RULE6 RULE11
  wire        c_edge = edges[0];
  wire        s_edge = edges[1];
  wire        w_edge = edges[2];
  wire        k_edge = edges[3]; // RULE1

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) prev <= 4'h0;
    else prev <= ins;
  end

  //==============================================================
  // Two-entry result buffer
  //==============================================================
  cepg_result_type buf_mem [CEPG_BUF_DEPTH];
  logic            rd_ptr;
  logic            wr_ptr;
  logic [1:0]      fill;
  logic            push_req;
  cepg_result_type push_data;
  wire             pop      = res_valid & res_ready;
  wire             in_ready = (fill != 2'h2) | pop;
  wire             push     = push_req & in_ready;

  assign res_valid = (fill != 2'h0);
  assign res_data  = buf_mem[rd_ptr];

  // A stall by the reader never overwrites a held word
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fill   <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk) begin
    if (push) buf_mem[wr_ptr] <= push_data;
  end

  //==============================================================
  // Measurement side
  //==============================================================
  cepg_mstate_type mstate, next_mstate;
  logic [CW-1:0]   cnt, next_cnt;
  logic [CW-1:0]   held;
  logic            held_v;
  logic            seen_s;
  logic            seen_w;

  wire is_pos  = (cfg.mode == CEPG_POS);
  wire is_sclk = (cfg.mode == CEPG_SEP_SCLK);
  wire is_sep  = cfg.mode inside {CEPG_SEP_ONE, CEPG_SEP_IMPL, CEPG_SEP_SCLK};
  wire counting = (mstate == M_COUNT);
  wire start_take = (mstate == M_WAIT) & s_edge;     // RULE3 RULE4
  wire stop_take  = counting & is_sep & w_edge;      // RULE5
  wire sclk_tick  = is_sclk & k_edge & (mstate != M_IDLE);
  wire [CW-1:0] cnt_inc = cnt + {{(CW-1){1'b0}}, c_edge};

  // Single mode pushes once and parks; buffered modes re-arm
  always_comb begin
    next_mstate = mstate;
    next_cnt    = counting ? cnt_inc : cnt;
    if (start_take) begin
      next_mstate = M_COUNT;
      next_cnt    = '0;
    end else if (stop_take) begin
      next_mstate = (cfg.mode == CEPG_SEP_ONE) ? M_DONE : M_WAIT; // RULE7 RULE8
      next_cnt    = '0;
    end
  end

  // Push selection: position capture, direct stop, or sample-clocked hold
  always_comb begin
    push_req        = 1'b0;
    push_data.kind  = CEPG_KIND_SEP;
    push_data.value = CEPG_CW'(cnt);
    if (is_pos & counting & k_edge) begin
      push_req       = 1'b1; // RULE1 RULE2
      push_data.kind = CEPG_KIND_POS;
    end else if (stop_take & ~is_sclk) begin
      push_req = 1'b1; // RULE5 RULE8
    end else if (sclk_tick & held_v) begin
      push_req        = 1'b1; // RULE9
      push_data.value = CEPG_CW'(held);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mstate <= M_IDLE;
      cnt    <= '0;
      held   <= '0;
      held_v <= 1'b0;
      seen_s <= 1'b0;
      seen_w <= 1'b0;
    end else if (arm) begin
      mstate <= is_pos ? M_COUNT : (is_sep ? M_WAIT : M_IDLE); // RULE23
      cnt    <= '0;
      held_v <= 1'b0;
      seen_s <= 1'b0;
      seen_w <= 1'b0;
    end else begin
      mstate <= next_mstate;
      cnt    <= next_cnt;
      if (stop_take & is_sclk) held <= cnt;
      held_v <= (stop_take & is_sclk) | (held_v & ~sclk_tick);
      seen_s <= start_take | (seen_s & ~sclk_tick);
      seen_w <= stop_take | (seen_w & ~sclk_tick);
    end
  end

  // Sticky error flags; an event in the arm cycle still sets them
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      overrun  <= 1'b0;
      res_lost <= 1'b0;
    end else begin
      overrun  <= (sclk_tick & ~(seen_s & seen_w)) | (overrun & ~arm); // RULE10
      res_lost <= (push_req & ~in_ready) | (res_lost & ~arm);
    end
  end

  assign meas_done = (mstate == M_DONE);

  //==============================================================
  // Generation side
  //==============================================================
  cepg_gstate_type gstate, next_gstate;
  logic [CW-1:0]   tcnt;
  logic [CW-1:0]   pcnt;
  logic [CW-1:0]   cur_high;
  logic [CW-1:0]   cur_low;
  logic            retrig_seen;
  logic            pend;
  cepg_spec_type   pend_spec;

  wire is_bimpl  = (cfg.mode == CEPG_BUF_IMPL);
  wire is_bsclk  = (cfg.mode == CEPG_BUF_SCLK);
  wire is_gen    = cfg.mode inside {CEPG_PULSE, CEPG_FINITE, CEPG_CONT, CEPG_BUF_IMPL,
                                    CEPG_BUF_SCLK};
  wire is_finite = cfg.mode inside {CEPG_PULSE, CEPG_FINITE};
  // Pause only when the window input is not the start trigger
  wire paused    = cfg.pause_en & ~cfg.trig_en & (window_in == cfg.window_rise); // RULE16 RULE19
  wire tick      = c_edge & ~paused;
  wire [CW-1:0] tnext = tcnt + 1'b1;
  wire [CW-1:0] pnext = pcnt + 1'b1;
  wire [CW-1:0] target = (gstate == G_DELAY) ? delay_ticks :
                         (gstate == G_HIGH) ? cur_high : cur_low;
  wire in_phase  = gstate inside {G_DELAY, G_LOW, G_HIGH};
  wire phase_end = in_phase & tick & (tnext >= target); // RULE11 RULE20
  wire [CW-1:0] total_lim = (cfg.mode == CEPG_PULSE) ? {{(CW-1){1'b0}}, 1'b1} : pulse_total;
  wire last_pulse = is_finite & (pnext >= total_lim);             // RULE13
  wire dly_all = cfg.delay_policy_set ? cfg.delay_every_retrigger
                                      : (cfg.mode == CEPG_PULSE); // RULE15
  wire trig_take = (gstate == G_TRIG) & w_edge;                   // RULE12 RULE14
  wire boundary  = (gstate == G_HIGH) & phase_end;
  wire sclk_take = is_bsclk & k_edge & spec_valid &
                   ~(gstate inside {G_IDLE, G_DONE});             // RULE21
  cepg_gstate_type first_phase;

  assign first_phase = is_bimpl ? G_FETCH : (is_bsclk ? G_LOW : G_HIGH);
  assign spec_ready  = ((gstate == G_FETCH) & is_bimpl) | sclk_take;
  assign gen_done    = (gstate == G_DONE);

  // Phase sequencing; window edges outside G_TRIG are not looked at
  always_comb begin
    next_gstate = gstate;
    unique case (gstate)
      G_IDLE:  next_gstate = G_IDLE;
      G_TRIG:  if (trig_take) begin
        next_gstate = (~retrig_seen | dly_all) ? G_DELAY : first_phase; // RULE15
      end
      G_DELAY: if (phase_end) next_gstate = first_phase;
      G_FETCH: if (spec_valid) next_gstate = G_LOW; // RULE21
      G_LOW:   if (phase_end) next_gstate = G_HIGH;
      G_HIGH:  if (phase_end) begin
        if (last_pulse) next_gstate = cfg.trig_en & cfg.retrig ? G_TRIG : G_DONE; // RULE13 RULE14
        else next_gstate = is_bimpl ? G_FETCH : (is_bsclk ? G_LOW : G_LOW);
      end
      G_DONE:  next_gstate = G_DONE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gstate      <= G_IDLE;
      tcnt        <= '0;
      pcnt        <= '0;
      cur_high    <= '0;
      cur_low     <= '0;
      retrig_seen <= 1'b0;
      pend        <= 1'b0;
      pend_spec   <= '0;
      pulse_out   <= 1'b0;
    end else if (arm) begin
      gstate      <= !is_gen ? G_IDLE : (cfg.trig_en ? G_TRIG : G_DELAY); // RULE18
      tcnt        <= '0;
      pcnt        <= '0;
      cur_high    <= high_ticks; // RULE22
      cur_low     <= low_ticks;
      retrig_seen <= 1'b0;
      pend        <= 1'b0;
      pulse_out   <= 1'b0;
    end else begin
      gstate <= next_gstate;
      if (phase_end | trig_take) tcnt <= '0;
      else if (in_phase & tick) tcnt <= tnext;
      if (trig_take) pcnt <= '0;
      else if (boundary) pcnt <= pnext;
      if (trig_take) retrig_seen <= 1'b1;
      if ((gstate == G_FETCH) & spec_valid) begin
        cur_low  <= CW'(spec.idle); // RULE21 RULE22
        cur_high <= CW'(spec.active);
      end else if (boundary & pend) begin
        cur_low  <= CW'(pend_spec.idle);
        cur_high <= CW'(pend_spec.active);
      end
      pend <= sclk_take | (pend & ~boundary);
      if (sclk_take) pend_spec <= spec;
      pulse_out <= (next_gstate == G_HIGH); // RULE11
    end
  end

  //==============================================================
  // Checks
  //==============================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  ignore_start_a: assert property (counting && s_edge && !w_edge && !arm |=> // RULE4
    mstate == M_COUNT && cnt == $past(cnt_inc)) else $error("start edge disturbed count");
  sep_push_a: assert property (stop_take && !is_sclk && !arm |-> push_req && // RULE5
    push_data.value == CEPG_CW'(cnt)) else $error("stop edge did not push count");
  single_park_a: assert property (mstate == M_DONE |-> !push_req) // RULE7
    else $error("single mode pushed after done");
  pos_cumulative_a: assert property (is_pos && counting && k_edge && !arm |=> // RULE2
    cnt == $past(cnt_inc)) else $error("sample edge altered position count");
  sclk_overrun_a: assert property (sclk_tick && !(seen_s && seen_w) && !arm |=> // RULE10
    overrun) else $error("overrun not flagged");
  arm_clear_a: assert property (arm |=> cnt == '0 && !held_v && tcnt == '0 && // RULE23
    !pulse_out) else $error("arm did not clear state");
  retrig_ignore_a: assert property (gstate == G_HIGH && w_edge && !phase_end && !arm |=> // RULE14
    gstate == G_HIGH) else $error("window edge disturbed pulse");
  pause_hold_a: assert property (paused && in_phase && !arm |=> // RULE19
    tcnt == $past(tcnt) && gstate == $past(gstate)) else $error("pause did not hold");
  finite_stop_a: assert property (boundary && last_pulse && !arm |=> // RULE13
    gstate inside {G_TRIG, G_DONE} && !pulse_out) else $error("finite train overran");
endmodule

// [test/cepg_src.sv]
`timescale 1ns/100ps
// ======================================
// Signal sources: count, start, window, sample
module cepg_src (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [3:0] req,
  input  wire logic [3:0] pol,
  output logic [3:0]      line
);
  logic [3:0] act;
  logic [1:0] age;

  // One request is two cycles active, then idle until the next; all bits of one request
  // switch together, so a trigger and a count tick can land in the same cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      act <= 4'h0;
      age <= 2'h0;
    end else if (req != 4'h0) begin
      act <= req;
      age <= 2'h2;
    end else if (age != 2'h0) begin
      age <= age - 2'h1;
      if (age == 2'h1) begin
        act <= 4'h0;
      end
    end
  end

  // Idle level is the inverse of the active level
  assign line = ~(act ^ pol);
endmodule

// [test/cepg_top_tb_top.sv]
`timescale 1ns/100ps
module cepg_top_tb_top import cepg_pkg::*; ();
  typedef struct packed {
    logic [3:0] pol;
    logic [3:0] n;
    logic [7:0] e;
  } cepg_row_type;
  logic            mclk, reset, arm, spec_valid, spec_ready, res_valid, res_ready;
  logic            overrun, res_lost, meas_done, gen_done, pulse_out;
  logic [31:0]     delay_ticks, high_ticks, low_ticks, pulse_total;
  logic [3:0]      req, line;
  cepg_cfg_type    cfg;
  cepg_spec_type   spec;
  cepg_result_type res_data;
  cepg_result_type got_q[$];
  int              fails, compares, takes;
  logic [3:0]      xf;
  // Outputs that must all be low while reset holds
  wire [6:0]       idle_outs = {res_valid, overrun, pulse_out, res_lost, meas_done,
                                gen_done, spec_ready};
  cepg_row_type    rows[4] = '{'{4'hF, 4'h3, 8'h3}, '{4'h0, 4'h1, 8'h1},
                               '{4'h5, 4'h4, 8'h4}, '{4'hA, 4'h0, 8'h0}};

  // ======================================
  // Design and sources
  cepg_top cepg_top_inst (.mclk(mclk), .reset(reset), .arm(arm), .cfg(cfg),
    .delay_ticks(delay_ticks), .high_ticks(high_ticks), .low_ticks(low_ticks),
    .pulse_total(pulse_total), .count_in(line[0]), .start_in(line[1]),
    .window_in(line[2]), .sample_in(line[3]), .spec(spec), .spec_valid(spec_valid),
    .spec_ready(spec_ready), .res_data(res_data), .res_valid(res_valid),
    .res_ready(res_ready), .overrun(overrun), .res_lost(res_lost),
    .meas_done(meas_done), .gen_done(gen_done), .pulse_out(pulse_out));
  cepg_src cepg_src_inst (.mclk(mclk), .reset(reset), .req(req),
    .pol({cfg.sample_rise, cfg.window_rise, cfg.start_rise, cfg.count_rise}),
    .line(line));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Collect every word popped, since a pop may end before a check looks
  always @(posedge mclk) if (res_valid === 1'b1 && res_ready === 1'b1) got_q.push_back(res_data);
  // Count spec words the design accepts
  always @(posedge mclk) if (spec_valid === 1'b1 && spec_ready === 1'b1) takes++;

  // ======================================
  // Helpers
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One pulse on the masked source lines, then let it settle
  task automatic fire(input logic [3:0] m);
    req <= m;
    tick(1);
    req <= 4'h0;
    tick(5);
  endtask

  task automatic start(input cepg_mode_type m, input logic [3:0] p, input logic t,
                       input logic [31:0] d, h, l, n);
    cfg <= '{mode: m, count_rise: p[0], start_rise: p[1], window_rise: p[2],
             sample_rise: p[3], trig_en: t, retrig: xf[3], pause_en: xf[2],
             delay_policy_set: xf[1], delay_every_retrigger: xf[0]};
    delay_ticks <= d;
    high_ticks <= h;
    low_ticks <= l;
    pulse_total <= n;
    tick(3);
    arm <= 1'b1;
    tick(1);
    arm <= 1'b0;
    tick(1);
    got_q.delete();
    takes = 0;
  endtask

  // Bounded wait for a result word, then compare it
  task automatic expq(input logic [1:0] k, input logic [31:0] v);
    int w;
    w = 0;
    while (got_q.size() == 0 && w < 30) begin
      tick(1);
      w++;
    end
    if (got_q.size() == 0) begin
      fails++;
      $display("Error result expected %0h seen none", v);
      print_verdict();
    end else chk("result", got_q.pop_front(), {k, v});
  endtask

  // Expected output level after each count edge; lf puts the low phase first
  task automatic gen(input int n, d, h, l, tot, input logic lf);
    int  k;
    logic e;
    for (int i = 1; i <= n; i++) begin
      fire(4'h1);
      k = i - d;
      e = (k >= 0) && (tot == 0 || k < tot * (h + l)) &&
          (lf ? (k % (h + l)) >= l : (k % (h + l)) < h);
      chk("pulse", 34'(pulse_out), 34'(e));
    end
  endtask

  // ======================================
  // Main sequence
  initial begin
    reset = 1'b1;
    arm = 1'b0;
    req = 4'h0;
    cfg = '0;
    res_ready = 1'b1;
    spec_valid = 1'b1;
    xf = 4'h0;
    spec = '{idle: 32'h1, active: 32'h2};
    {delay_ticks, high_ticks, low_ticks, pulse_total} = '0;
    tick(10);
    chk("reset", 34'(idle_outs), 34'h0);
    reset <= 1'b0;
    tick(1);
    // Table of single separations: polarities, counts, stray starts
    foreach (rows[r]) begin
      start(CEPG_SEP_ONE, rows[r].pol, 1'b0, 1, 1, 1, 1);
      fire(4'h2);
      for (int i = 0; i < rows[r].n; i++) begin
        fire(4'h1);
        if (i == 0) fire(4'h2);
      end
      fire(4'h4);
      expq(CEPG_KIND_SEP, 32'(rows[r].e));
    end
    chk("meas_done", 34'(meas_done), 34'h1);
    fire(4'h2);
    fire(4'h1);
    fire(4'h4);
    chk("ignored", 34'(got_q.size()), 34'h0);
    $display("Test single separation done");
    start(CEPG_SEP_IMPL, 4'hF, 1'b0, 1, 1, 1, 1);
    for (int j = 2; j > 0; j--) begin
      fire(4'h2);
      repeat (j) fire(4'h1);
      fire(4'h4);
      expq(CEPG_KIND_SEP, 32'(j));
    end
    $display("Test implicit separation done");
    start(CEPG_SEP_SCLK, 4'hF, 1'b0, 1, 1, 1, 1);
    fire(4'h2);
    repeat (3) fire(4'h1);
    fire(4'h4);
    chk("held", 34'(got_q.size()), 34'h0);
    fire(4'h8);
    expq(CEPG_KIND_SEP, 32'h3);
    chk("overrun", 34'(overrun), 34'h0);
    fire(4'h8);
    chk("overrun", 34'(overrun), 34'h1);
    $display("Test sampled separation done");
    start(CEPG_POS, 4'h7, 1'b0, 1, 1, 1, 1);
    repeat (3) fire(4'h1);
    fire(4'h8);
    expq(CEPG_KIND_POS, 32'h3);
    repeat (2) fire(4'h1);
    fire(4'h8);
    expq(CEPG_KIND_POS, 32'h5);
    res_ready <= 1'b0;
    repeat (3) fire(4'h8);
    chk("res_lost", 34'(res_lost), 34'h1);
    res_ready <= 1'b1;
    expq(CEPG_KIND_POS, 32'h5);
    expq(CEPG_KIND_POS, 32'h5);
    tick(2);
    chk("drained", 34'(res_valid), 34'h0);
    start(CEPG_POS, 4'h7, 1'b0, 1, 1, 1, 1);
    fire(4'h1);
    fire(4'h8);
    expq(CEPG_KIND_POS, 32'h1);
    $display("Test position done");
    start(CEPG_PULSE, 4'hE, 1'b0, 2, 3, 1, 1);
    gen(8, 2, 3, 1, 1, 1'b0);
    chk("gen_done", 34'(gen_done), 34'h1);
    start(CEPG_CONT, 4'hF, 1'b0, 1, 2, 3, 1);
    gen(12, 1, 2, 3, 0, 1'b0);
    start(CEPG_FINITE, 4'hF, 1'b0, 1, 1, 1, 2);
    gen(8, 1, 1, 1, 2, 1'b0);
    chk("gen_done", 34'(gen_done), 34'h1);
    start(CEPG_PULSE, 4'hF, 1'b1, 1, 2, 1, 1);
    gen(2, 99, 1, 1, 1, 1'b0);
    fire(4'h4);
    gen(4, 1, 2, 1, 1, 1'b0);
    start(CEPG_BUF_IMPL, 4'hF, 1'b0, 1, 5, 5, 1);
    gen(9, 1, 2, 1, 0, 1'b1);
    chk("takes", 34'(takes), 34'h3);
    // Retrigger with pause asked for: window stays a trigger, delay on every trigger
    xf = 4'hC;
    start(CEPG_PULSE, 4'hF, 1'b1, 1, 2, 1, 1);
    fire(4'h4);
    gen(1, 1, 2, 1, 1, 1'b0);
    fire(4'h5);
    chk("busy_window", 34'(pulse_out), 34'h1);
    gen(1, -1, 2, 1, 1, 1'b0);
    fire(4'h4);
    gen(3, 1, 2, 1, 1, 1'b0);
    // Explicit policy: delay only before the first trigger
    xf = 4'hA;
    start(CEPG_PULSE, 4'hF, 1'b1, 2, 1, 1, 1);
    fire(4'h4);
    gen(3, 2, 1, 1, 1, 1'b0);
    fire(4'h4);
    chk("no_delay", 34'(pulse_out), 34'h1);
    gen(1, 99, 1, 1, 1, 1'b0);
    // Pause level holds the phase through a count edge
    xf = 4'h4;
    start(CEPG_CONT, 4'hF, 1'b0, 1, 1, 1, 1);
    gen(1, 1, 1, 1, 0, 1'b0);
    fire(4'h5);
    chk("paused", 34'(pulse_out), 34'h1);
    gen(2, 0, 1, 1, 0, 1'b0);
    // Sample-clocked train: initial widths until the taken spec reaches a boundary
    xf = 4'h0;
    start(CEPG_BUF_SCLK, 4'hF, 1'b0, 1, 1, 1, 1);
    gen(3, 1, 1, 1, 0, 1'b1);
    fire(4'h8);
    gen(2, 0, 1, 1, 0, 1'b1);
    gen(5, 0, 2, 1, 0, 1'b1);
    chk("takes", 34'(takes), 34'h1);
    $display("Test generation done");
    // Reset in mid-pulse clears every output but res_data
    reset <= 1'b1;
    tick(2);
    chk("reset", 34'(idle_outs), 34'h0);
    reset <= 1'b0;
    tick(1);
    $display("Test reset done");
    print_verdict();
  end
endmodule
